// >>> src/gptc_defines.svh
// constants for the gated prescaled timer control block
`ifndef GPTC_DEFINES_SVH
`define GPTC_DEFINES_SVH
`define GPTC_CTRL_ADDR 12'h000
`define GPTC_COUNT_ADDR 12'h004
`define GPTC_RUN_BIT 15
`define GPTC_HALT_IDLE_BIT 13
`define GPTC_GATE_BIT 6
`define GPTC_PS_HI 5
`define GPTC_PS_LO 4
`define GPTC_SRC_BIT 1
`define GPTC_CTRL_MASK 16'hA072
`define GPTC_CTRL_RESET 16'h0000
`define GPTC_DIV1 8'h00
`define GPTC_DIV8 8'h07
`define GPTC_DIV64 8'h3F
`define GPTC_DIV256 8'hFF
`endif

// >>> src/gptc_pkg.sv
// types for the gated prescaled timer control block
package gptc_pkg;
    typedef struct packed {
        logic run;
        logic halt_in_idle;
        logic gated_accumulate_en;
        logic [1:0] input_prescale_sel;
        logic clock_source_sel;
    } gptc_ctrl_s;
    typedef enum logic [1:0] {
        GPTC_HALTED,
        GPTC_TIMING,
        GPTC_GATED,
        GPTC_EXTERNAL
    } gptc_mode_e;
endpackage

// >>> src/gptc_timer.sv
// gated prescaled 16-bit timer with control register on apb
// Notes on behaviour
// - the gate bit 6 selects gated accumulation when the internal clock is chosen.
// - with the external clock chosen the gate bit is ignored.
// - prescale bits 5 to 4 divide by 1, 8, 64 or 256.
// - with source bit 1 set the timer counts rising edges of the external pin.
// - with source bit 1 clear the timer counts peripheral clock cycles.
// - in combined 32-bit mode this timer's run, gate, prescale and source bits do nothing.
// - unimplemented control bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "gptc_defines.svh"
module gptc_timer
    import gptc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic idle_mode,
    input wire logic combined_32bit_mode,
    input wire logic ext_timer_clock_pin,
    input wire logic gate_pin,
    output logic [15:0] timer_count,
    output logic timer_active
);
    logic [15:0] timer_control;
    logic [15:0] next_timer_control;
    logic [15:0] next_timer_count;
    logic [7:0] prescale_cnt;
    logic [7:0] next_prescale_cnt;
    logic [2:0] ext_sync;
    logic [2:0] gate_sync;
    logic [2:0] next_ext_sync;
    logic [2:0] next_gate_sync;
    logic ext_level;
    logic gate_level;
    logic next_ext_level;
    logic next_gate_level;
    logic ext_rise;
    logic tick_src;
    logic tick;
    logic running;
    logic wr_en;
    logic [7:0] div_max;
    gptc_ctrl_s ctrl;
    gptc_mode_e mode;

    function automatic logic [7:0] ps_limit(input logic [1:0] sel);
        case (sel)
            2'h0: ps_limit = `GPTC_DIV1;
            2'h1: ps_limit = `GPTC_DIV8;
            2'h2: ps_limit = `GPTC_DIV64;
            default: ps_limit = `GPTC_DIV256;
        endcase
    endfunction

    assign ctrl.run = timer_control[`GPTC_RUN_BIT];
    assign ctrl.halt_in_idle = timer_control[`GPTC_HALT_IDLE_BIT];
    assign ctrl.gated_accumulate_en = timer_control[`GPTC_GATE_BIT];
    assign ctrl.input_prescale_sel = timer_control[`GPTC_PS_HI:`GPTC_PS_LO];
    assign ctrl.clock_source_sel = timer_control[`GPTC_SRC_BIT];

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel & penable & pwrite & clk_en;

    // three-stage sync, change counted when stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync <= 3'h0;
            gate_sync <= 3'h0;
            ext_level <= 1'b0;
            gate_level <= 1'b0;
        end else if (clk_en) begin
            ext_sync <= next_ext_sync;
            gate_sync <= next_gate_sync;
            ext_level <= next_ext_level;
            gate_level <= next_gate_level;
        end
    end

    always_comb begin
        next_ext_sync = {ext_sync[1:0], ext_timer_clock_pin};
        next_gate_sync = {gate_sync[1:0], gate_pin};
        next_ext_level = (ext_sync[1] == ext_sync[2]) ? ext_sync[2] : ext_level;
        next_gate_level = (gate_sync[1] == gate_sync[2]) ? gate_sync[2] : gate_level;
    end

    assign ext_rise = next_ext_level & ~ext_level;

    always_comb begin
        if (combined_32bit_mode || !ctrl.run || (idle_mode && ctrl.halt_in_idle)) begin
            mode = GPTC_HALTED;
        end else if (ctrl.clock_source_sel) begin
            mode = GPTC_EXTERNAL;
        end else if (ctrl.gated_accumulate_en) begin
            mode = GPTC_GATED;
        end else begin
            mode = GPTC_TIMING;
        end
    end

    assign running = (mode != GPTC_HALTED);
    assign div_max = ps_limit(ctrl.input_prescale_sel);

    always_comb begin
        case (mode)
            GPTC_TIMING: tick_src = 1'b1;
            GPTC_GATED: tick_src = gate_level;
            GPTC_EXTERNAL: tick_src = ext_rise;
            default: tick_src = 1'b0;
        endcase
    end

    always_comb begin
        next_prescale_cnt = prescale_cnt;
        tick = 1'b0;
        if (running && tick_src) begin
            if (prescale_cnt >= div_max) begin
                next_prescale_cnt = 8'h00;
                tick = 1'b1;
            end else begin
                next_prescale_cnt = prescale_cnt + 8'h01;
            end
        end
        next_timer_count = tick ? timer_count + 16'h0001 : timer_count;
        next_timer_control = timer_control;
        if (wr_en && paddr == `GPTC_CTRL_ADDR) begin
            next_timer_control = pwdata[15:0] & `GPTC_CTRL_MASK;
            // prescaler restarts on control write
            next_prescale_cnt = 8'h00;
        end
        if (wr_en && paddr == `GPTC_COUNT_ADDR) begin
            next_timer_count = pwdata[15:0];
            next_prescale_cnt = 8'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control <= `GPTC_CTRL_RESET;
            timer_count <= 16'h0000;
            prescale_cnt <= 8'h00;
        end else if (clk_en) begin
            timer_control <= next_timer_control;
            timer_count <= next_timer_count;
            prescale_cnt <= next_prescale_cnt;
        end
    end

    assign timer_active = running;

    always_comb begin
        case (paddr)
            `GPTC_CTRL_ADDR: prdata = {16'h0000, timer_control};
            `GPTC_COUNT_ADDR: prdata = {16'h0000, timer_count};
            default: prdata = 32'h00000000;
        endcase
    end

    sequence s_count_up;
        timer_count == $past(timer_count) + 16'h0001;
    endsequence

    property p_ctrl_mask;
        @(posedge pclk) disable iff (!presetn)
        (timer_control & ~`GPTC_CTRL_MASK) == 16'h0000;
    endproperty
    a_ctrl_mask: assert property (p_ctrl_mask) else $error("reserved bit set");

    property p_stop;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !ctrl.run && !wr_en) |=> $stable(timer_count);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");

    property p_combined;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && combined_32bit_mode && !wr_en) |=> $stable(timer_count);
    endproperty
    a_combined: assert property (p_combined) else $error("count moved in combined mode");

    property p_idle;
        @(posedge pclk) disable iff (!presetn)
        (idle_mode && ctrl.halt_in_idle) |-> !timer_active;
    endproperty
    a_idle: assert property (p_idle) else $error("active in idle halt");

    property p_run_1to1;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && mode == GPTC_TIMING && ctrl.input_prescale_sel == 2'h0 && !wr_en)
        |=> s_count_up;
    endproperty
    a_run_1to1: assert property (p_run_1to1) else $error("1:1 count missed");

    property p_gate_low;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && mode == GPTC_GATED && !gate_level && !wr_en) |=> $stable(timer_count);
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("counted with gate low");

    property p_ext_mode;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && running && ctrl.clock_source_sel && ctrl.gated_accumulate_en && !gate_level
        && ctrl.input_prescale_sel == 2'h0 && ext_rise && !wr_en) |=> s_count_up;
    endproperty
    a_ext_mode: assert property (p_ext_mode) else $error("gate not ignored");

    property p_ext_norise;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && mode == GPTC_EXTERNAL && !ext_rise && !wr_en) |=> $stable(timer_count);
    endproperty
    a_ext_norise: assert property (p_ext_norise) else $error("count without edge");

    property p_prescale;
        @(posedge pclk) disable iff (!presetn)
        tick |-> prescale_cnt == div_max;
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescale period wrong");

    property p_gate_on;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && mode == GPTC_GATED && gate_level && ctrl.input_prescale_sel == 2'h0 && !wr_en)
        |=> s_count_up;
    endproperty
    a_gate_on: assert property (p_gate_on) else $error("gated source wrong");
endmodule
`default_nettype wire

// >>> sim/gptc_pin_model.sv
// model of the external clock and gate pins
`timescale 1ns/1ps
`default_nettype none
module gptc_pin_model (
    input wire logic pclk,
    output logic ext_clk,
    output logic gate
);
    initial begin
        ext_clk = 1'b0;
        gate = 1'b0;
    end
    task set_gate(input logic lvl);
        @(posedge pclk);
        gate <= lvl;
    endtask
    task pulse(input int n);
        repeat (n) begin
            repeat (4) @(posedge pclk);
            ext_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_clk <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> sim/gated_prescaled_timer_control_bench.sv
// bench for the gated prescaled timer control block
`timescale 1ns/1ps
`default_nettype none
`include "gptc_defines.svh"
module gated_prescaled_timer_control_bench;
    logic pclk, presetn, clk_en, psel, penable, pwrite, idle_mode, comb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, ext_clk, gate, act, act_seen;
    logic [15:0] cnt;
    int n_errors, tests_run, dv;
    gptc_timer DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
        .combined_32bit_mode(comb), .ext_timer_clock_pin(ext_clk), .gate_pin(gate),
        .timer_count(cnt), .timer_active(act));
    gptc_pin_model pm (.pclk(pclk), .ext_clk(ext_clk), .gate(gate));
    task close_out;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1) begin
            n_errors++;
            close_out();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task run_for(input logic [15:0] c, input int n);
        apb(1'b1, `GPTC_COUNT_ADDR, 32'h0);
        apb(1'b1, `GPTC_CTRL_ADDR, {16'h0000, c});
        repeat (n) @(posedge pclk);
        act_seen = act;
        apb(1'b1, `GPTC_CTRL_ADDR, 32'h0);
        apb(1'b0, `GPTC_COUNT_ADDR, 32'h0);
    endtask
    task t_regs;
        apb(1'b0, `GPTC_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        chk({30'h0, pready, pslverr}, 32'h2);
        apb(1'b1, `GPTC_CTRL_ADDR, 32'hFFFFFFFF);
        apb(1'b0, `GPTC_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0000A072);
        clk_en <= 1'b0;
        apb(1'b1, `GPTC_CTRL_ADDR, 32'h0);
        clk_en <= 1'b1;
        apb(1'b0, `GPTC_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0000A072);
        apb(1'b1, `GPTC_CTRL_ADDR, 32'h0);
    endtask
    task t_prescale;
        for (int s = 0; s < 4; s++) begin
            dv = (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 64 : 256;
            run_for({8'h80, 2'h0, s[1:0], 4'h0}, 4 * dv);
            chk(rd, (4 * dv + 3) / dv);
        end
        rd = 32'hFFFF;
        repeat (20) @(posedge pclk);
        apb(1'b0, `GPTC_COUNT_ADDR, 32'h0);
        chk(rd, 32'h4);
    endtask
    task t_idle_comb;
        idle_mode <= 1'b1;
        run_for(16'hA000, 40);
        chk(rd, 32'h0);
        chk({31'h0, act_seen}, 32'h0);
        run_for(16'h8000, 40);
        chk(rd, 32'h2B);
        chk({31'h0, act_seen}, 32'h1);
        comb <= 1'b1;
        run_for(16'h8000, 40);
        chk(rd, 32'h0);
        chk({31'h0, act_seen}, 32'h0);
        idle_mode <= 1'b0;
        comb <= 1'b0;
    endtask
    task t_gate_ext;
        run_for(16'h8040, 40);
        chk(rd, 32'h0);
        pm.set_gate(1'b1);
        repeat (6) @(posedge pclk);
        run_for(16'h8040, 40);
        chk(rd, 32'h2B);
        pm.set_gate(1'b0);
        apb(1'b1, `GPTC_COUNT_ADDR, 32'h0);
        apb(1'b1, `GPTC_CTRL_ADDR, 32'h8042);
        pm.pulse(5);
        repeat (8) @(posedge pclk);
        apb(1'b1, `GPTC_CTRL_ADDR, 32'h0);
        apb(1'b0, `GPTC_COUNT_ADDR, 32'h0);
        chk(rd, 32'h5);
        chk({16'h0000, cnt}, 32'h5);
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, idle_mode, comb} = 6'h00;
        clk_en = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_errors = 0;
        tests_run = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_prescale();
        t_idle_comb();
        t_gate_ext();
        close_out();
    end
endmodule
`default_nettype wire
